/* File: logic/fbio_ctrl.sv */
// Controller end: AHB-Lite register front for the fieldbus master
`timescale 1ns/100ps
`default_nettype none
module fbio_ctrl
  import fbio_pkg::*;
(
  // System
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Interrupt
  output logic             irq_o,
  // Fieldbus link
  fbio_if.ctrl             link
);

  fbio_state_e       state_q;
  logic              ap_wr_q;
  logic [7:0]        ap_addr_q;
  logic              wr_en;
  logic [2:0]        cfg_q;
  logic [31:0]       hdr_q;
  logic [15:0]       len_q;
  logic [7:0]        pidx_q;
  logic [7:0]        pay_q [PAY_DEPTH];
  logic [31:0]       req_q;
  logic [7:0]        reqv_q;
  logic [15:0]       rsp_q;
  logic [IRQ_W-1:0]  irq_st_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  ev;
  logic [IRQ_W-1:0]  irq_next;
  logic [8:0]        pos_q;
  logic [8:0]        alen;
  logic [8:0]        poff;
  logic [7:0]        tx_byte;
  logic              go_cfg;
  logic              go_frame;
  logic              go_req;

  // Zero-wait slave: writes land in the data phase
  assign wr_en = ap_wr_q;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      ap_wr_q     <= 1'b0;
      ap_addr_q   <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      ap_wr_q     <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
      ap_addr_q   <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
      begin
        case ({haddr_i[7:2], 2'b00})
          REG_CFG:  hrdata_o <= {29'h0, cfg_q};
          REG_HDR:  hrdata_o <= hdr_q;
          REG_LEN:  hrdata_o <= {16'h0, len_q};
          REG_PIDX: hrdata_o <= {24'h0, pidx_q};
          REG_REQ:  hrdata_o <= req_q;
          REG_REQV: hrdata_o <= {24'h0, reqv_q};
          REG_RSP:  hrdata_o <= {16'h0, rsp_q};
          REG_STAT: hrdata_o <= {31'h0, state_q != FBIO_IDLE};
          REG_IRQ:  hrdata_o <= {29'h0, irq_st_q};
          REG_MASK: hrdata_o <= {29'h0, irq_mask_q};
          default:  hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Commands are dropped while a transfer is in progress
  assign go_cfg   = wr_en && ap_addr_q == REG_CMD && hwdata_i[CMD_CFG];
  assign go_frame = wr_en && ap_addr_q == REG_CMD && hwdata_i[CMD_FRAME];
  assign go_req   = wr_en && ap_addr_q == REG_CMD && hwdata_i[CMD_REQ];

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      cfg_q      <= 3'h0;
      hdr_q      <= 32'h0000_0000;
      len_q      <= 16'h0000;
      req_q      <= 32'h0000_0000;
      reqv_q     <= 8'h00;
      irq_mask_q <= '0;
    end
    else if (wr_en)
    begin
      case (ap_addr_q)
        REG_CFG:  cfg_q      <= hwdata_i[2:0];
        REG_HDR:  hdr_q      <= hwdata_i;
        REG_LEN:  len_q      <= hwdata_i[15:0];
        REG_REQ:  req_q      <= hwdata_i;
        REG_REQV: reqv_q     <= hwdata_i[7:0];
        REG_MASK: irq_mask_q <= hwdata_i[IRQ_W-1:0];
        default:  cfg_q      <= cfg_q;
      endcase
    end
  end

  // Payload staging, index advances after each data write
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      pidx_q <= 8'h00;
    else if (wr_en && ap_addr_q == REG_PIDX)
      pidx_q <= hwdata_i[7:0];
    else if (wr_en && ap_addr_q == REG_PDAT)
      pidx_q <= pidx_q + 8'h01;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en && ap_addr_q == REG_PDAT)
      pay_q[pidx_q] <= hwdata_i[7:0];
  end

  // Assembly length is six plus entry length, capped at the longest
  assign alen = (len_q > 16'h00FF) ? ASM_LEN_MAX
                : ASM_PAY_FIRST + {1'b0, len_q[7:0]}; // RULE_05
  assign poff = pos_q - ASM_PAY_FIRST;

  always_comb
  begin
    case (pos_q)
      ASM_FRAG_NUM:  tx_byte = hdr_q[7:0];            // RULE_01
      ASM_FRAG_REM:  tx_byte = hdr_q[15:8];
      ASM_FRAG_SIZE: tx_byte = hdr_q[23:16];
      ASM_FLAGS:     tx_byte = hdr_q[31:24];
      ASM_LEN_LO:    tx_byte = len_q[7:0];            // RULE_02
      ASM_LEN_HI:    tx_byte = len_q[15:8];
      default:       tx_byte = pay_q[poff[7:0]];      // RULE_03
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_q          <= FBIO_IDLE;
      pos_q            <= 9'h000;
      rsp_q            <= 16'h0000;
      link.asm_valid   <= 1'b0;
      link.asm_first   <= 1'b0;
      link.asm_last    <= 1'b0;
      link.asm_byte    <= 8'h00;
      link.cfg_valid   <= 1'b0;
      link.cfg_bytes   <= 24'h000000;
      link.req_valid   <= 1'b0;
      link.req_service <= 8'h00;
      link.req_class   <= 8'h00;
      link.req_inst    <= 8'h00;
      link.req_attr    <= 8'h00;
      link.req_value   <= 8'h00;
    end
    else
    begin
      link.asm_valid <= 1'b0;
      link.asm_first <= 1'b0;
      link.asm_last  <= 1'b0;
      link.cfg_valid <= 1'b0;
      link.req_valid <= 1'b0;
      case (state_q)
        FBIO_IDLE:
        begin
          pos_q <= 9'h000;
          if (go_cfg)
            state_q <= FBIO_CFG;
          else if (go_frame)
            state_q <= FBIO_FRAME;
          else if (go_req)
            state_q <= FBIO_REQ;
        end
        FBIO_CFG:
        begin
          link.cfg_valid <= 1'b1;                     // RULE_06
          link.cfg_bytes <= {7'h00, cfg_q[2], 7'h00, cfg_q[1],
                             7'h00, cfg_q[0]};
          state_q        <= FBIO_IDLE;
        end
        FBIO_FRAME:
        begin
          link.asm_valid <= 1'b1;
          link.asm_first <= pos_q == 9'h000;
          link.asm_last  <= pos_q == alen - 9'h001;
          link.asm_byte  <= tx_byte;
          pos_q          <= pos_q + 9'h001;
          if (pos_q == alen - 9'h001)
            state_q <= FBIO_IDLE;
        end
        FBIO_REQ:
        begin
          link.req_valid   <= 1'b1;
          link.req_service <= req_q[7:0];
          link.req_class   <= req_q[15:8];
          link.req_inst    <= req_q[23:16];
          link.req_attr    <= req_q[31:24];
          link.req_value   <= reqv_q;
          state_q          <= FBIO_WAIT;
        end
        FBIO_WAIT:
        begin
          if (link.rsp_valid)
          begin
            rsp_q   <= {link.rsp_value, link.rsp_status};
            state_q <= FBIO_IDLE;
          end
        end
        default: state_q <= FBIO_IDLE;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  assign ev[EV_CFG]   = state_q == FBIO_CFG;
  assign ev[EV_FRAME] = state_q == FBIO_FRAME && pos_q == alen - 9'h001;
  assign ev[EV_RSP]   = state_q == FBIO_WAIT && link.rsp_valid;
  assign irq_next     = (irq_st_q & ~((wr_en && ap_addr_q == REG_IRQ)
                        ? hwdata_i[IRQ_W-1:0] : '0)) | ev;

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      irq_st_q <= '0;
      irq_o    <= 1'b0;
    end
    else
    begin
      irq_st_q <= irq_next;
      irq_o    <= |(irq_next & irq_mask_q);
    end
  end

endmodule
`default_nettype wire

/* File: logic/fbio_device.sv */
// Device end: output assembly capture, parameters, switching lines
//
// Contract
// (RULE_01) Bytes 0-2: fragment number, remaining, size
// (RULE_02) Entry length low byte 4, high 5
// (RULE_03) Payload from byte 6, last at 260
// (RULE_04) Accept assembly lengths 1 to 261 bytes
// (RULE_05) Controller sets length to six plus entry
// (RULE_06) Three-byte configuration applied at connection setup
// (RULE_07) Config byte 0 bit 0 selects handshake
// (RULE_08) Config byte 1 bit 0: result fragmentation
// (RULE_09) Config byte 2 bit 0: entry fragmentation
// (RULE_10) All parameters default to zero
// (RULE_11) Answer get 0x0E, set 0x10, class 0x67
// (RULE_12) Two line instances, attributes five to nine
// (RULE_13) Toggle flags act on change, not level
// (RULE_14) Drive attribute: 0 low, 1 high
// (RULE_15) Counter reset on rising attribute edge only
// (RULE_16) Counter clear also clears comparison flags
// (RULE_17) Handshake: controller acknowledges before new results; handshake_mode_o is only driven out, no acknowledge is waited for
// (RULE_18) Latch header and payload on toggle change
`timescale 1ns/100ps
`default_nettype none
module fbio_device
  import fbio_pkg::*;
(
  // System
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_i,
  // Fieldbus link
  fbio_if.dev                       link,
  // Switching lines
  input  wire logic [1:0]           line_i,
  output logic      [1:0]           line_o,
  output logic      [1:0]           line_oe_n_o,
  input  wire logic [1:0]           act_event_i,
  input  wire logic [1:0][15:0]     cmp_limit_i,
  // Latched entry
  output logic                      entry_new_o,
  output logic      [7:0]           frag_num_o,
  output logic      [7:0]           frag_rem_o,
  output logic      [7:0]           frag_size_o,
  output logic                      new_data_o,
  output logic      [15:0]          entry_len_o,
  input  wire logic [7:0]           entry_idx_i,
  output logic      [7:0]           entry_byte_o,
  // Parameters
  output logic                      handshake_mode_o,
  output logic                      result_frag_o,
  output logic                      entry_frag_o
);
  // Checks path, service, attribute and value of one request
  function automatic logic [7:0] req_status(
    input logic [7:0] srv,
    input logic [7:0] cls,
    input logic [7:0] inst,
    input logic [7:0] attr,
    input logic [7:0] val
  );
    logic [7:0] st;
    st = ST_OK;
    if (cls != CLS_SWIO || inst == 8'h00 || inst > 8'h02)
      st = ST_BAD_PATH;
    else if (srv != SRV_GET && srv != SRV_SET)
      st = ST_BAD_SRV;
    else if (attr < ATTR_STATE || attr > ATTR_CMP_TGL)
      st = ST_NO_ATTR;
    else if (srv == SRV_SET && attr != ATTR_DRIVE && attr != ATTR_CNT_RST)
      st = ST_READ_ONLY;
    else if (srv == SRV_SET && val > 8'h01)
      st = ST_BAD_VALUE;
    return st;
  endfunction
  logic [8:0]  pos_q;
  logic [8:0]  idx;
  logic [8:0]  pay_off;
  logic        take_q;
  logic        tog_q;
  logic        new_now;
  logic [7:0]  hdr_q [3];
  logic [7:0]  pay_q [PAY_DEPTH];
  logic [1:0]  sync1_q, sync2_q;
  logic [7:0]  st;
  logic [7:0]  get_val;
  logic        li, wr_ok;
  logic        drive_q [NUM_LINES];
  logic        rst_attr_q [NUM_LINES];
  logic        cmp_q [NUM_LINES];
  logic        cmp_tgl_q [NUM_LINES];
  logic [15:0] cnt_q [NUM_LINES];
  logic        oe_n_q;
  // Stream position; bytes past the longest assembly are dropped
  assign idx     = link.asm_first ? 9'h000 : pos_q;
  assign pay_off = idx - ASM_PAY_FIRST;
  assign new_now = link.asm_valid && idx == ASM_FLAGS
                   && link.asm_byte[NEW_ENTRY_BIT] != tog_q;
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      pos_q <= 9'h000;
    else if (link.asm_valid)
      pos_q <= (idx < ASM_LEN_MAX) ? idx + 9'h001 : ASM_LEN_MAX; // RULE_04
  end
  // Header bytes wait here until the toggle byte decides
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      hdr_q <= '{default: 8'h00};
    else if (link.asm_valid && idx < ASM_FLAGS)
      hdr_q[idx[1:0]] <= link.asm_byte; // RULE_01
  end
  // Toggle edge detection opens the frame for latching
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      take_q <= 1'b0;
      tog_q  <= 1'b0;
    end
    else if (link.asm_valid && idx == ASM_FRAG_NUM)
      take_q <= 1'b0;
    else if (link.asm_valid && idx == ASM_FLAGS)
    begin
      take_q <= new_now; // RULE_13
      tog_q  <= link.asm_byte[NEW_ENTRY_BIT]; // RULE_13
    end
  end
  // Header commit; a frame without a toggle change leaves all untouched
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      frag_num_o  <= 8'h00;
      frag_rem_o  <= 8'h00;
      frag_size_o <= 8'h00;
      new_data_o  <= 1'b0;
      entry_len_o <= 16'h0000;
    end
    else if (new_now)
    begin
      frag_num_o  <= hdr_q[0]; // RULE_18
      frag_rem_o  <= hdr_q[1]; // RULE_01
      frag_size_o <= hdr_q[2]; // RULE_01
      new_data_o  <= link.asm_byte[NEW_DATA_BIT];
    end
    else if (link.asm_valid && take_q && idx == ASM_LEN_LO)
      entry_len_o[7:0] <= link.asm_byte; // RULE_02
    else if (link.asm_valid && take_q && idx == ASM_LEN_HI)
      entry_len_o[15:8] <= link.asm_byte; // RULE_02
  end
  // Payload lands directly; entry_new marks the frame end as consistent
  always_ff @(posedge sys_clk_i)
  begin
    if (link.asm_valid && take_q && idx >= ASM_PAY_FIRST
        && idx <= ASM_PAY_LAST)
      pay_q[pay_off[7:0]] <= link.asm_byte; // RULE_03
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      entry_new_o  <= 1'b0;
      entry_byte_o <= 8'h00;
    end
    else
    begin
      entry_new_o  <= link.asm_valid && link.asm_last
                      && (take_q || new_now); // RULE_18
      entry_byte_o <= pay_q[entry_idx_i];
    end
  end
  // Parameter set from the configuration assembly
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      handshake_mode_o <= CFG_RESET[CFG_BIT]; // RULE_10
      result_frag_o    <= CFG_RESET[CFG_BIT]; // RULE_10
      entry_frag_o     <= CFG_RESET[CFG_BIT]; // RULE_10
    end
    else if (link.cfg_valid) // RULE_06
    begin
      handshake_mode_o <= link.cfg_bytes[CFG_MODE*8+CFG_BIT]; // RULE_07
      result_frag_o    <= link.cfg_bytes[CFG_RES_FRAG*8+CFG_BIT]; // RULE_08
      entry_frag_o     <= link.cfg_bytes[CFG_ENT_FRAG*8+CFG_BIT]; // RULE_09
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    sync1_q <= line_i;
    sync2_q <= sync1_q;
  end
  assign st    = req_status(link.req_service, link.req_class,
                            link.req_inst, link.req_attr, link.req_value);
  assign li    = link.req_inst[1];
  assign wr_ok = link.req_valid && st == ST_OK
                 && link.req_service == SRV_SET;
  always_comb
  begin
    get_val = 8'h00;
    case (link.req_attr)
      ATTR_STATE:   get_val = {7'h00, sync2_q[li]};
      ATTR_DRIVE:   get_val = {7'h00, drive_q[li]};
      ATTR_CNT_RST: get_val = {7'h00, rst_attr_q[li]};
      ATTR_CMP:     get_val = {7'h00, cmp_q[li]};
      ATTR_CMP_TGL: get_val = {7'h00, cmp_tgl_q[li]};
      default:      get_val = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      link.rsp_valid  <= 1'b0;
      link.rsp_status <= ST_OK;
      link.rsp_value  <= 8'h00;
    end
    else
    begin
      link.rsp_valid  <= link.req_valid; // RULE_11
      link.rsp_status <= st; // RULE_11
      link.rsp_value  <= (st == ST_OK && link.req_service == SRV_GET)
                         ? get_val : 8'h00; // RULE_12
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    oe_n_q <= reset_i;
  end
  for (genvar i = 0; i < NUM_LINES; i++)
  begin : g_line
    logic        sel;
    logic        clr;
    logic [15:0] cnt_inc;
    assign sel     = wr_ok && li == 1'(i);
    assign clr     = sel && link.req_attr == ATTR_CNT_RST
                     && link.req_value[0] && !rst_attr_q[i]; // RULE_15
    assign cnt_inc = (cnt_q[i] == 16'hFFFF) ? cnt_q[i] : cnt_q[i] + 16'h0001;
    always_ff @(posedge sys_clk_i)
    begin
      if (reset_i)
      begin
        drive_q[i]    <= 1'b0;
        rst_attr_q[i] <= 1'b0;
      end
      else if (sel && link.req_attr == ATTR_DRIVE)
        drive_q[i] <= link.req_value[0]; // RULE_14
      else if (sel && link.req_attr == ATTR_CNT_RST)
        rst_attr_q[i] <= link.req_value[0];
    end
    // Counter saturates rather than wrap and fake a fresh crossing
    always_ff @(posedge sys_clk_i)
    begin
      if (reset_i || clr)
      begin
        cnt_q[i]     <= 16'h0000; // RULE_15
        cmp_q[i]     <= 1'b0; // RULE_16
        cmp_tgl_q[i] <= 1'b0; // RULE_16
      end
      else if (act_event_i[i])
      begin
        cnt_q[i] <= cnt_inc;
        if (cnt_inc > cmp_limit_i[i])
        begin
          cmp_q[i]     <= 1'b1;
          cmp_tgl_q[i] <= !cmp_tgl_q[i];
        end
      end
    end
    assign line_o[i]      = drive_q[i]; // RULE_14
    assign line_oe_n_o[i] = oe_n_q;
  end
endmodule
`default_nettype wire

/* File: logic/fbio_if.sv */
// Link between the fieldbus master and the device
`timescale 1ns/100ps
`default_nettype none
interface fbio_if;
  // Output assembly stream, one byte a cycle
  logic        asm_valid;
  logic        asm_first;
  logic        asm_last;
  logic [7:0]  asm_byte;
  // Configuration assembly, byte 0 in the low bits
  logic        cfg_valid;
  logic [23:0] cfg_bytes;
  // Attribute request and answer
  logic        req_valid;
  logic [7:0]  req_service;
  logic [7:0]  req_class;
  logic [7:0]  req_inst;
  logic [7:0]  req_attr;
  logic [7:0]  req_value;
  logic        rsp_valid;
  logic [7:0]  rsp_status;
  logic [7:0]  rsp_value;

  modport dev (
    input  asm_valid, asm_first, asm_last, asm_byte, cfg_valid, cfg_bytes,
    input  req_valid, req_service, req_class, req_inst, req_attr, req_value,
    output rsp_valid, rsp_status, rsp_value
  );
  modport ctrl (
    output asm_valid, asm_first, asm_last, asm_byte, cfg_valid, cfg_bytes,
    output req_valid, req_service, req_class, req_inst, req_attr, req_value,
    input  rsp_valid, rsp_status, rsp_value
  );
endinterface
`default_nettype wire

/* File: logic/fbio_pkg.sv */
// Constants and types shared by both ends of the fieldbus assembly link
package fbio_pkg;
  // Output assembly layout
  localparam logic [8:0] ASM_FRAG_NUM  = 9'h000;
  localparam logic [8:0] ASM_FRAG_REM  = 9'h001;
  localparam logic [8:0] ASM_FRAG_SIZE = 9'h002;
  localparam logic [8:0] ASM_FLAGS     = 9'h003;
  localparam logic [8:0] ASM_LEN_LO    = 9'h004;
  localparam logic [8:0] ASM_LEN_HI    = 9'h005;
  localparam logic [8:0] ASM_PAY_FIRST = 9'h006;
  localparam logic [8:0] ASM_PAY_LAST  = 9'h104;
  localparam logic [8:0] ASM_LEN_MAX   = 9'h105;
  localparam int         PAY_DEPTH     = 256;
  localparam int         NEW_ENTRY_BIT = 0;
  localparam int         NEW_DATA_BIT  = 1;
  // Configuration assembly: byte offsets, bit and reset value
  localparam int         CFG_MODE      = 0;
  localparam int         CFG_RES_FRAG  = 1;
  localparam int         CFG_ENT_FRAG  = 2;
  localparam int         CFG_BIT       = 0;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  // Switching input/output object
  localparam int         NUM_LINES     = 2;
  localparam logic [7:0] CLS_SWIO      = 8'h67;
  localparam logic [7:0] SRV_GET       = 8'h0E;
  localparam logic [7:0] SRV_SET       = 8'h10;
  localparam logic [7:0] ATTR_STATE    = 8'h05;
  localparam logic [7:0] ATTR_DRIVE    = 8'h06;
  localparam logic [7:0] ATTR_CNT_RST  = 8'h07;
  localparam logic [7:0] ATTR_CMP      = 8'h08;
  localparam logic [7:0] ATTR_CMP_TGL  = 8'h09;
  // Answer status codes
  localparam logic [7:0] ST_OK         = 8'h00;
  localparam logic [7:0] ST_BAD_PATH   = 8'h05;
  localparam logic [7:0] ST_BAD_SRV    = 8'h08;
  localparam logic [7:0] ST_BAD_VALUE  = 8'h09;
  localparam logic [7:0] ST_READ_ONLY  = 8'h0E;
  localparam logic [7:0] ST_NO_ATTR    = 8'h14;
  // Controller registers on AHB-Lite (byte addresses)
  localparam logic [7:0] REG_CMD       = 8'h00;
  localparam logic [7:0] REG_CFG       = 8'h04;
  localparam logic [7:0] REG_HDR       = 8'h08;
  localparam logic [7:0] REG_LEN       = 8'h0C;
  localparam logic [7:0] REG_PIDX      = 8'h10;
  localparam logic [7:0] REG_PDAT      = 8'h14;
  localparam logic [7:0] REG_REQ       = 8'h18;
  localparam logic [7:0] REG_REQV      = 8'h1C;
  localparam logic [7:0] REG_RSP       = 8'h20;
  localparam logic [7:0] REG_STAT      = 8'h24;
  localparam logic [7:0] REG_IRQ       = 8'h28;
  localparam logic [7:0] REG_MASK      = 8'h2C;
  localparam int         CMD_CFG       = 0;
  localparam int         CMD_FRAME     = 1;
  localparam int         CMD_REQ       = 2;
  localparam int         IRQ_W         = 3;
  localparam int         EV_CFG        = 0;
  localparam int         EV_FRAME      = 1;
  localparam int         EV_RSP        = 2;

  typedef enum logic [2:0] {
    FBIO_IDLE, FBIO_CFG, FBIO_FRAME, FBIO_REQ, FBIO_WAIT
  } fbio_state_e;
endpackage

/* File: test/fbio_properties.sv */
// Timing and answer checks on the link between the two ends
`timescale 1ns/100ps
`default_nettype none
module fbio_properties
  import fbio_pkg::*;
(
  // System
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  // Link
  input wire logic       asm_valid,
  input wire logic       asm_last,
  input wire logic       cfg_valid,
  input wire logic       req_valid,
  input wire logic [7:0] req_service,
  input wire logic [7:0] req_class,
  input wire logic [7:0] req_inst,
  input wire logic [7:0] req_attr,
  input wire logic [7:0] req_value,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic [7:0] rsp_value
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic pok;
  logic gs;
  assign pok = req_class == CLS_SWIO && req_inst inside {8'h01, 8'h02};
  assign gs  = req_service == SRV_GET || req_service == SRV_SET;
  sequence s_answer;
    ##1 rsp_valid ##1 !rsp_valid;
  endsequence
  a_rsp_timing: assert property (req_valid |-> s_answer)
    else $error("answer not one cycle after request");
  a_rsp_cause: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  a_bad_path: assert property (req_valid && gs && !pok
    |=> rsp_status == ST_BAD_PATH) else $error("bad path accepted");
  a_bad_srv: assert property (req_valid && pok && !gs
    |=> rsp_status == ST_BAD_SRV) else $error("bad service accepted");
  a_no_attr: assert property (req_valid && pok && gs
    && !(req_attr inside {[8'h05:8'h09]}) |=> rsp_status == ST_NO_ATTR)
    else $error("reserved attribute accepted");
  a_read_only: assert property (req_valid && pok && req_service == SRV_SET
    && req_attr inside {8'h05, 8'h08, 8'h09}
    |=> rsp_status == ST_READ_ONLY) else $error("read-only set accepted");
  a_bad_value: assert property (req_valid && pok && req_service == SRV_SET
    && req_attr inside {8'h06, 8'h07} && req_value > 8'h01
    |=> rsp_status == ST_BAD_VALUE) else $error("value above one taken");
  a_get_bool: assert property (req_valid && pok && req_service == SRV_GET
    && req_attr inside {[8'h05:8'h09]}
    |=> rsp_status == ST_OK && rsp_value <= 8'h01)
    else $error("get answer not boolean");
  a_cfg_pulse: assert property (cfg_valid |=> !cfg_valid)
    else $error("configuration sent twice");
  a_frame_run: assert property (asm_valid && !asm_last |=> asm_valid)
    else $error("gap inside output assembly");
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Register-level bench driving the controller end against the device end
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import fbio_pkg::*;
  logic             sys_clk_i, reset_i, hsel, hwrite, hready, hresp, irq;
  logic             entry_new_o, new_data_o, handshake_mode_o;
  logic             result_frag_o, entry_frag_o;
  logic [1:0]       htrans, line_i, line_o, line_oe_n_o, act_event_i;
  logic [1:0][15:0] cmp_limit_i;
  logic [7:0]       frag_num_o, frag_rem_o, frag_size_o, entry_idx_i;
  logic [7:0]       entry_byte_o;
  logic [15:0]      entry_len_o;
  logic [31:0]      haddr, hwdata, hrdata, r;
  int               n_errors, check_count, nb, n_new;
  fbio_if link();
  fbio_ctrl u_fbio_ctrl(.sys_clk_i, .reset_i, .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .irq_o(irq), .link);
  fbio_device u_fbio_device(.sys_clk_i, .reset_i, .link, .line_i, .line_o,
    .line_oe_n_o, .act_event_i, .cmp_limit_i, .entry_new_o, .frag_num_o,
    .frag_rem_o, .frag_size_o, .new_data_o, .entry_len_o, .entry_idx_i,
    .entry_byte_o, .handshake_mode_o, .result_frag_o, .entry_frag_o);
  fbio_properties u_fbio_properties(.sys_clk_i, .reset_i,
    .asm_valid(link.asm_valid), .asm_last(link.asm_last),
    .cfg_valid(link.cfg_valid), .req_valid(link.req_valid),
    .req_service(link.req_service), .req_class(link.req_class),
    .req_inst(link.req_inst), .req_attr(link.req_attr),
    .req_value(link.req_value), .rsp_valid(link.rsp_valid),
    .rsp_status(link.rsp_status), .rsp_value(link.rsp_value));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // Byte count restarts on the first byte so a frame length can be compared
  always @(posedge sys_clk_i)
  begin
    if (link.asm_valid === 1'b1) nb <= link.asm_first ? 1 : nb + 1;
    if (entry_new_o === 1'b1) n_new <= n_new + 1;
  end
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string n);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    r = hrdata;
    chk(hresp, 0, "hresp");
  endtask
  task automatic wirq();
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge sys_clk_i);
    chk(irq, 1, "irq");
    bus(1'b1, REG_IRQ, 32'h7);
  endtask
  task automatic frm(input logic [31:0] h, l);
    bus(1'b1, REG_HDR, h);
    bus(1'b1, REG_LEN, l);
    bus(1'b1, REG_CMD, 32'h2);
    wirq();
  endtask
  task automatic rq(input logic [31:0] q, v, e);
    bus(1'b1, REG_REQV, v);
    bus(1'b1, REG_REQ, q);
    bus(1'b1, REG_CMD, 32'h4);
    wirq();
    bus(1'b0, REG_RSP, 32'h0);
    chk(r & 32'hFFFF, e, "answer");
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    complete_run();
  end
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, act_event_i, entry_idx_i} = '0;
    line_i = 2'h2;
    cmp_limit_i = {16'h1, 16'h1};
    reset_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    bus(1'b1, REG_MASK, 32'h0);
    chk({handshake_mode_o, result_frag_o, entry_frag_o}, 0, "param");
    bus(1'b1, REG_CFG, 32'h5);
    bus(1'b1, REG_CMD, 32'h1);
    repeat (8) @(posedge sys_clk_i);
    chk(irq, 0, "masked irq");
    bus(1'b0, REG_IRQ, 32'h0);
    chk(r, 1, "irq status");
    bus(1'b1, REG_IRQ, 32'h1);
    bus(1'b1, REG_MASK, 32'h7);
    chk({handshake_mode_o, result_frag_o, entry_frag_o}, 5, "param");
    bus(1'b1, REG_CFG, 32'h2);
    bus(1'b1, REG_CMD, 32'h1);
    wirq();
    chk({handshake_mode_o, result_frag_o, entry_frag_o}, 2, "param");
    bus(1'b0, 8'h30, 32'h0);
    chk(r, 0, "unmapped");
    bus(1'b1, REG_PIDX, 32'h0);
    for (int k = 0; k < 3; k++) bus(1'b1, REG_PDAT, 32'hA0 + k);
    frm(32'h03332211, 32'h3);
    chk({frag_num_o, frag_rem_o, frag_size_o}, 32'h112233, "hdr");
    chk({new_data_o, entry_len_o}, 32'h10003, "length");
    chk(nb, 9, "bytes");
    for (int k = 0; k < 3; k++)
    begin
      entry_idx_i <= 8'(k);
      repeat (2) @(posedge sys_clk_i);
      chk(entry_byte_o, 32'hA0 + k, "payload");
    end
    frm(32'h03332211, 32'h3);
    chk(n_new, 1, "same toggle");
    frm(32'h0, 32'h100);
    chk(nb, 261, "bytes");
    chk(n_new, 2, "new toggle");
    rq(32'h06016710, 1, 32'h0);
    chk({line_oe_n_o, line_o}, 1, "line");
    rq(32'h0601670E, 0, 32'h100);
    rq(32'h0502670E, 0, 32'h100);
    rq(32'h06016710, 2, 32'h9);
    rq(32'h05016710, 0, 32'hE);
    rq(32'h0401670E, 0, 32'h14);
    rq(32'h0501680E, 0, 32'h5);
    rq(32'h0503670E, 0, 32'h5);
    rq(32'h05016701, 0, 32'h8);
    for (int p = 0; p < 2; p++)
    begin
      repeat (2)
      begin
        @(posedge sys_clk_i) act_event_i <= 2'h1;
        @(posedge sys_clk_i) act_event_i <= 2'h0;
      end
      rq(32'h0801670E, 0, 32'h100);
      rq(32'h0901670E, 0, 32'h100);
      rq(32'h07016710, 1 - p, 32'h0);
      rq(32'h0801670E, 0, p ? 32'h100 : 32'h0);
      rq(32'h0901670E, 0, p ? 32'h100 : 32'h0);
    end
    complete_run();
  end
endmodule
`default_nettype wire
